// ==== shared/boh_pkg.sv ====
// Constants, opcodes, register map and types for the bus opcode handler
`default_nettype none
package boh_pkg;
    // Opcodes handled or sent by the block
    localparam logic [7:0] OP_SCAN_UNQ  = 8'h30;
    localparam logic [7:0] OP_VOL_FLOOR = 8'h26;
    localparam logic [7:0] OP_VOL_LEVEL = 8'h27;
    localparam logic [7:0] OP_REP_STAT  = 8'h4a;
    localparam logic [7:0] OP_XSTART    = 8'h50;
    localparam logic [7:0] OP_XBODY     = 8'h51;
    localparam logic [7:0] OP_XEND      = 8'h52;
    localparam logic [7:0] OP_XERROR    = 8'h53;
    localparam logic [7:0] OP_XTAL      = 8'h54;
    // Transfer error codes
    localparam logic [7:0] ERR_OK      = 8'h00;
    localparam logic [7:0] ERR_RESEND  = 8'h01;
    localparam logic [7:0] ERR_SHORT   = 8'h02;
    localparam logic [7:0] ERR_OVER    = 8'h03;
    localparam logic [7:0] ERR_COUNT   = 8'h04;
    localparam logic [7:0] ERR_BUFSIZE = 8'h05;
    // Flag positions inside the first data byte
    localparam int FLAG1_BIT = 0;
    localparam int FLAG2_BIT = 1;
    // Register indices on the plain register port
    localparam logic [3:0] REG_CTRL   = 4'h0;
    localparam logic [3:0] REG_XTAL   = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_VOL    = 4'h3;
    localparam logic [3:0] REG_XSEL   = 4'h4;
    localparam logic [3:0] REG_XDATA  = 4'h5;
    // Field positions
    localparam int XTAL_SHIFT_BIT = 8;
    localparam int ST_FLOOR_BIT   = 0;
    localparam int ST_OPTVOL_BIT  = 1;
    localparam int ST_REPON_BIT   = 2;
    localparam int ST_REPTX_BIT   = 3;
    localparam int ST_TXBUSY_BIT  = 4;
    // Values after reset
    localparam logic [7:0] DEF_VOL_RST = 8'h80;
    localparam logic [7:0] OP_VOL_RST  = 8'h80;
    // Source address of crystal commands: group zero, radio device one
    localparam logic [7:0] XTAL_SRC_ADDR = 8'h01;
    // Timing: bus hold-off after our own busy release
    localparam int CLK_NS     = 10;
    localparam int GAP_NS     = 2500000;
    localparam int GAP_CYCLES = (GAP_NS + CLK_NS - 1) / CLK_NS;
    // Transfer sizing defaults
    localparam int NOPT_DEF = 4;
    localparam int BUFD_DEF = 16;
    // Transmit sequencer states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b00,
        TX_SEND = 2'b01
    } boh_tx_t;
endpackage
`default_nettype wire

// ==== src/boh_handler.sv ====
// Radio-side handler for volume, scan, repeater, crystal and transfer opcodes
`default_nettype none
module boh_handler #(
    parameter int NOPT       = boh_pkg::NOPT_DEF,
    parameter int BUFD       = boh_pkg::BUFD_DEF,
    parameter int GAP_CYCLES = boh_pkg::GAP_CYCLES
) (
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // Received message from the framing layer
    input  wire logic        rxValid,
    input  wire logic        rxRequest,
    input  wire logic [7:0]  rxOpcode,
    input  wire logic [7:0]  rxAddr,
    input  wire logic [7:0]  rxData1,
    input  wire logic [7:0]  rxData2,
    input  wire logic [7:0]  rxData3,
    // Message to transmit
    output var  logic        txValid,
    output var  logic [7:0]  txOpcode,
    output var  logic [7:0]  txAddr,
    output var  logic [7:0]  txData1,
    output var  logic [7:0]  txData2,
    output var  logic [7:0]  txData3,
    input  wire logic        txReady,
    input  wire logic        busyRelease,
    // Radio context
    input  wire logic        onPriorityChan,
    input  wire logic        modeChange,
    input  wire logic        opVolWrite,
    input  wire logic [7:0]  opVolume,
    output var  logic        scanResume,
    output var  logic [7:0]  activeVol,
    // Register port
    input  wire logic [3:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output var  logic [15:0] regRdata
);
    localparam int OIW = (NOPT > 1) ? $clog2(NOPT) : 1;
    localparam int BW  = $clog2(BUFD);
    localparam int GW  = $clog2(GAP_CYCLES + 1);
    localparam int NE  = NOPT * BUFD;

    // Message decode
    wire logic isUnq   = rxValid && rxOpcode == boh_pkg::OP_SCAN_UNQ;
    wire logic isFloor = rxValid && rxOpcode == boh_pkg::OP_VOL_FLOOR;
    wire logic isLevel = rxValid && rxOpcode == boh_pkg::OP_VOL_LEVEL;
    wire logic isRep   = rxValid && rxOpcode == boh_pkg::OP_REP_STAT;
    wire logic optOk   = rxAddr < 8'(NOPT);
    wire logic isStart = rxValid && optOk && rxOpcode == boh_pkg::OP_XSTART;
    wire logic isBody  = rxValid && optOk && rxOpcode == boh_pkg::OP_XBODY;
    wire logic isEnd   = rxValid && optOk && rxOpcode == boh_pkg::OP_XEND;
    wire logic flag1   = rxData1[boh_pkg::FLAG1_BIT];
    wire logic flag2   = rxData1[boh_pkg::FLAG2_BIT];
    wire logic [OIW-1:0] optIdx = rxAddr[OIW-1:0];

    // Registers
    logic [7:0]  defVol_q, opVol_q, optVol_q, volOut_q;
    logic        floorOn_q, optActive_q, optModeRevert_q;
    logic        repOn_q, repTx_q, scan_q;
    logic [8:0]  xtal_q;
    logic [7:0]  xsel_q;
    logic [15:0] rdata_q;
    logic [7:0]  ptr_q   [NOPT];
    logic [7:0]  start_q [NOPT];
    logic [7:0]  cnt_q   [NOPT];
    logic [7:0]  buf_q   [NE];
    logic        pendErr_q, pendVol_q, pendXtal_q;
    logic [7:0]  errAddr_q, errOff_q, errCode_q, volAddr_q;
    logic [GW-1:0] gap_q;
    boh_pkg::boh_tx_t state_q;
    logic        txValid_q;
    logic [7:0]  txOp_q, txAddr_q, txD1_q, txD2_q, txD3_q;

    // Volume selection: option level, else operator level, then floor
    wire logic [7:0] baseVol  = optActive_q ? optVol_q : opVol_q;
    wire logic       floorUp  = floorOn_q && baseVol < defVol_q;
    wire logic [7:0] volNext  = floorUp ? defVol_q : baseVol;

    // Current option's transfer state
    wire logic [7:0] curPtr  = ptr_q[optIdx];
    wire logic [7:0] curCnt  = cnt_q[optIdx];
    wire logic [7:0] curRel  = curPtr - start_q[optIdx];
    wire logic       overCnt = curRel > curCnt;
    wire logic       inBuf0  = curPtr < 8'(BUFD);
    wire logic       inBuf1  = curPtr < 8'(BUFD - 1);
    wire logic       second  = curRel < curCnt;
    // Byte writes; a second byte past the announced count is padding
    wire logic we0 = isBody && !overCnt && inBuf0;
    wire logic we1 = isBody && second && inBuf1;
    wire logic [BW+OIW-1:0] wa0 = {optIdx, curPtr[BW-1:0]};
    wire logic [7:0]        p1  = curPtr + 8'h01;
    wire logic [BW+OIW-1:0] wa1 = {optIdx, p1[BW-1:0]};
    wire logic [7:0] ptrStep = second ? 8'h02 : 8'h01;

    // Fault detection and end check
    wire logic startErr = isStart && rxData2 >= 8'(BUFD);
    wire logic bodyCntE = isBody && overCnt;
    wire logic bodyBufE = isBody && !overCnt && !inBuf0;
    wire logic [7:0] endCode =
        (rxData2 != curCnt) ? boh_pkg::ERR_COUNT :
        (curRel <= rxData2) ? boh_pkg::ERR_SHORT : boh_pkg::ERR_OK;
    wire logic errReq = startErr || bodyCntE || bodyBufE || isEnd;
    wire logic [7:0] errCode =
        isEnd    ? endCode :
        bodyCntE ? boh_pkg::ERR_OVER : boh_pkg::ERR_BUFSIZE;
    wire logic [7:0] errOff = isStart ? rxData1 : curPtr;

    // Transmit arbitration: errors first, then level replies, then crystal
    // A release in this very cycle also holds the next message back
    wire logic txFree   = state_q == boh_pkg::TX_IDLE &&
        gap_q == '0 && !busyRelease;
    wire logic takeErr  = txFree && pendErr_q;
    wire logic takeVol  = txFree && !pendErr_q && pendVol_q;
    wire logic takeXtal = txFree && !pendErr_q && !pendVol_q && pendXtal_q;
    wire logic [7:0] selOp =
        pendErr_q ? boh_pkg::OP_XERROR :
        pendVol_q ? boh_pkg::OP_VOL_LEVEL : boh_pkg::OP_XTAL;
    wire logic [7:0] selAddr =
        pendErr_q ? errAddr_q :
        pendVol_q ? volAddr_q : boh_pkg::XTAL_SRC_ADDR;
    wire logic [7:0] selD1 =
        pendErr_q ? errOff_q :
        pendVol_q ? 8'h00 : {7'h00, xtal_q[boh_pkg::XTAL_SHIFT_BIT]};
    wire logic [7:0] selD2 =
        pendErr_q ? errCode_q :
        pendVol_q ? 8'h00 : xtal_q[7:0];
    wire logic [7:0] selD3 = pendVol_q ? baseVol : 8'h00;

    // Register read decode
    wire logic [15:0] stWord = 16'({pendErr_q || pendVol_q || pendXtal_q,
        repTx_q, repOn_q, optActive_q, floorOn_q});
    wire logic [15:0] rdMux =
        regAddr == boh_pkg::REG_CTRL   ? {8'h00, defVol_q} :
        regAddr == boh_pkg::REG_XTAL   ? {7'h00, xtal_q} :
        regAddr == boh_pkg::REG_STATUS ? stWord :
        regAddr == boh_pkg::REG_VOL    ? {baseVol, volOut_q} :
        regAddr == boh_pkg::REG_XSEL   ? {8'h00, xsel_q} :
        regAddr == boh_pkg::REG_XDATA  ?
            {ptr_q[xsel_q[BW+OIW-1:BW]], buf_q[xsel_q[BW+OIW-1:0]]} :
        16'h0000;
    wire logic xtalWr = regWrite && regAddr == boh_pkg::REG_XTAL;

    // Software registers; read data stand only in the cycle after a read
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            defVol_q <= boh_pkg::DEF_VOL_RST;
            xtal_q   <= 9'h000;
            xsel_q   <= 8'h00;
            rdata_q  <= 16'h0000;
        end else begin
            if (regWrite && regAddr == boh_pkg::REG_CTRL)
                defVol_q <= regWdata[7:0];
            if (xtalWr)
                xtal_q <= regWdata[8:0];
            if (regWrite && regAddr == boh_pkg::REG_XSEL)
                xsel_q <= regWdata[7:0];
            rdata_q <= regRead ? rdMux : 16'h0000;
        end
    end

    // Operator and floor state; floor flag cleared only by reset or command
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            opVol_q   <= boh_pkg::OP_VOL_RST;
            floorOn_q <= 1'b0;
            volOut_q  <= boh_pkg::OP_VOL_RST;
        end else begin
            if (opVolWrite)
                opVol_q <= opVolume;
            if (isFloor)
                floorOn_q <= flag1;
            volOut_q <= volNext;
        end
    end

    // Option level; a mode change reverts it only when flag2 asked for that
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            optVol_q        <= 8'h00;
            optActive_q     <= 1'b0;
            optModeRevert_q <= 1'b0;
        end else if (isLevel && !rxRequest) begin
            optVol_q        <= rxData3;
            optActive_q     <= flag1 || flag2;
            optModeRevert_q <= flag2;
        end else if (modeChange && optModeRevert_q) begin
            optActive_q <= 1'b0;
        end
    end

    // Repeater status and scan resume pulse
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            repOn_q <= 1'b0;
            repTx_q <= 1'b0;
            scan_q  <= 1'b0;
        end else begin
            if (isRep) begin
                repOn_q <= flag1;
                repTx_q <= flag2;
            end
            scan_q <= isUnq && !onPriorityChan;
        end
    end

    // Per-option pointer, start offset and announced count
    generate
        for (genvar o = 0; o < NOPT; o++) begin : g_opt
            wire logic hit = optIdx == OIW'(o);
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n) begin
                    ptr_q[o]   <= 8'h00;
                    start_q[o] <= 8'h00;
                    cnt_q[o]   <= 8'h00;
                end else if (hit && isStart) begin
                    ptr_q[o]   <= rxData1;
                    start_q[o] <= rxData1;
                    cnt_q[o]   <= rxData2;
                end else if (hit && isBody) begin
                    ptr_q[o] <= ptr_q[o] + ptrStep;
                end
            end
        end
        // Buffer bytes; both body bytes may land in one cycle
        for (genvar e = 0; e < NE; e++) begin : g_buf
            always_ff @(posedge mclk or negedge reset_n) begin
                if (!reset_n)
                    buf_q[e] <= 8'h00;
                else if (we0 && wa0 == (BW+OIW)'(e))
                    buf_q[e] <= rxData1;
                else if (we1 && wa1 == (BW+OIW)'(e))
                    buf_q[e] <= rxData2;
            end
        end
    endgenerate

    // Pending answers; a new event wins over its own hand-off
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            pendErr_q  <= 1'b0;
            pendVol_q  <= 1'b0;
            pendXtal_q <= 1'b0;
            errAddr_q  <= 8'h00;
            errOff_q   <= 8'h00;
            errCode_q  <= 8'h00;
            volAddr_q  <= 8'h00;
        end else begin
            pendErr_q  <= errReq || (pendErr_q && !takeErr);
            pendVol_q  <= (isLevel && rxRequest) ||
                          (pendVol_q && !takeVol);
            pendXtal_q <= xtalWr || (pendXtal_q && !takeXtal);
            if (errReq) begin
                errAddr_q <= rxAddr;
                errOff_q  <= errOff;
                errCode_q <= errCode;
            end
            if (isLevel && rxRequest)
                volAddr_q <= rxAddr;
        end
    end

    // Hold-off after our own busy release; protects other pending senders
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            gap_q <= '0;
        else if (busyRelease)
            gap_q <= GW'(GAP_CYCLES);
        else if (gap_q != '0)
            gap_q <= gap_q - GW'(1);
    end

    // Transmit sequencer: message held until the framing layer takes it
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q   <= boh_pkg::TX_IDLE;
            txValid_q <= 1'b0;
            txOp_q    <= 8'h00;
            txAddr_q  <= 8'h00;
            txD1_q    <= 8'h00;
            txD2_q    <= 8'h00;
            txD3_q    <= 8'h00;
        end else begin
            case (state_q)
                boh_pkg::TX_IDLE: begin
                    if (takeErr || takeVol || takeXtal) begin
                        state_q   <= boh_pkg::TX_SEND;
                        txValid_q <= 1'b1;
                        txOp_q    <= selOp;
                        txAddr_q  <= selAddr;
                        txD1_q    <= selD1;
                        txD2_q    <= selD2;
                        txD3_q    <= selD3;
                    end
                end
                boh_pkg::TX_SEND: begin
                    if (txReady) begin
                        state_q   <= boh_pkg::TX_IDLE;
                        txValid_q <= 1'b0;
                    end
                end
                default: begin
                    state_q   <= boh_pkg::TX_IDLE;
                    txValid_q <= 1'b0;
                end
            endcase
        end
    end

    // Outputs
    assign txValid    = txValid_q;
    assign txOpcode   = txOp_q;
    assign txAddr     = txAddr_q;
    assign txData1    = txD1_q;
    assign txData2    = txD2_q;
    assign txData3    = txD3_q;
    assign scanResume = scan_q;
    assign activeVol  = volOut_q;
    assign regRdata   = rdata_q;

    // Checks on the guarded behaviour
    a_scan_resume: assert property (@(posedge mclk) disable iff (!reset_n)
        isUnq |=> scanResume == !$past(onPriorityChan))
        else $error("scan resume does not follow priority state");
    a_floor_raise: assert property (@(posedge mclk) disable iff (!reset_n)
        floorUp |=> activeVol == $past(defVol_q))
        else $error("floor did not raise volume to default");
    a_floor_keep: assert property (@(posedge mclk) disable iff (!reset_n)
        !floorUp |=> activeVol == $past(baseVol))
        else $error("volume not taken from selected level");
    a_level_read: assert property (@(posedge mclk) disable iff (!reset_n)
        takeVol |=> txValid && txData3 == $past(baseVol) && txData1 == 8'h00)
        else $error("level reply does not carry the unforced level");
    a_start_ptr: assert property (@(posedge mclk) disable iff (!reset_n)
        isStart |=> ptr_q[$past(optIdx)] == $past(rxData1))
        else $error("start did not load the option pointer");
    a_body_step: assert property (@(posedge mclk) disable iff (!reset_n)
        isBody |=> ptr_q[$past(optIdx)] == $past(curPtr) + $past(ptrStep))
        else $error("body did not advance the option pointer");
    a_err_report: assert property (@(posedge mclk) disable iff (!reset_n)
        errReq |=> pendErr_q && errCode_q == $past(errCode))
        else $error("transfer fault not queued for report");
    a_size_code: assert property (@(posedge mclk) disable iff (!reset_n)
        startErr |=> errCode_q == boh_pkg::ERR_BUFSIZE)
        else $error("oversize start not reported with code 05");
    a_end_ack: assert property (@(posedge mclk) disable iff (!reset_n)
        (isEnd && rxData2 == curCnt && curRel > rxData2)
        |=> errCode_q == boh_pkg::ERR_OK)
        else $error("complete transfer not acknowledged with 00");
    a_buf_guard: assert property (@(posedge mclk) disable iff (!reset_n)
        bodyBufE |=> pendErr_q && errCode_q == boh_pkg::ERR_BUFSIZE)
        else $error("buffer overflow not reported with code 05");
    a_xtal_group: assert property (@(posedge mclk) disable iff (!reset_n)
        (txValid && txOpcode == boh_pkg::OP_XTAL) |-> txAddr[7:5] == 3'h0)
        else $error("crystal command with non-zero source group");
    a_gap_wait: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(txValid) |-> $past(gap_q) == '0 && !$past(busyRelease))
        else $error("message offered inside the busy hold-off");
endmodule // boh_handler
`default_nettype wire

// ==== test/boh_option_model.sv ====
// Option device model: sends bus messages and takes the handler's replies
`default_nettype none
module boh_option_model #(
    // Address of this option: group one, device two
    parameter logic [7:0] OWN_ADDR = 8'h22
) (
    // Clock and pace of acceptance
    input  wire logic        mclk,
    input  wire logic        slow,
    // Messages toward the handler
    output var  logic        rxValid,
    output var  logic        rxRequest,
    output var  logic [39:0] rxMsg,
    // Messages from the handler
    input  wire logic        txValid,
    input  wire logic [39:0] txMsg,
    output var  logic        txReady
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0]  waitCnt;
    logic [39:0] gotMsg;
    int          nTx;
    logic        xtalShift;
    initial begin
        xtalShift = 1'b0;
        rxValid = 1'b0;
        rxRequest = 1'b0;
        rxMsg = '0;
        txReady = 1'b0;
        waitCnt = '0;
        gotMsg = '0;
        nTx = 0;
    end
    // Ready is a one-cycle answer, prompt or five cycles late when slow
    always @(posedge mclk) begin
        txReady <= 1'b0;
        if (txValid && txReady) begin
            gotMsg <= txMsg;
            nTx <= nTx + 1;
            waitCnt <= '0;
            // Device address 00 reaches every device of the group
            if (txMsg[39:32] == boh_pkg::OP_XTAL &&
                txMsg[15:13] == OWN_ADDR[7:5] &&
                (txMsg[12:8] == 5'h00 || txMsg[12:8] == OWN_ADDR[4:0]))
                xtalShift <= txMsg[16];
        end else if (txValid) begin
            if (!slow || waitCnt == 3'h5) txReady <= 1'b1;
            else waitCnt <= waitCnt + 3'h1;
        end
    end
    // One message per call; lines show junk once released
    task automatic send(input logic req, input logic [39:0] m);
        rxValid <= 1'b1;
        rxRequest <= req;
        rxMsg <= m;
        @(posedge mclk);
        rxValid <= 1'b0;
        rxMsg <= ~m;
    endtask
endmodule // boh_option_model
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the bus opcode handler
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        mclk, reset_n, slow, rxValid, rxRequest, txValid, txReady;
    logic        busyRelease, onPriorityChan, modeChange, opVolWrite;
    logic        scanResume, regWrite, regRead;
    logic [39:0] rxMsg, txMsg;
    logic [7:0]  opVolume, activeVol;
    logic [3:0]  regAddr;
    logic [15:0] regWdata, regRdata, rd;
    int          n_errors = 0, tests_run = 0, cycles = 0;
    boh_handler #(.NOPT(4), .BUFD(16), .GAP_CYCLES(20)) boh_handler_i (
        .mclk(mclk), .reset_n(reset_n), .rxValid(rxValid),
        .rxRequest(rxRequest), .rxOpcode(rxMsg[39:32]),
        .rxAddr(rxMsg[31:24]), .rxData1(rxMsg[23:16]),
        .rxData2(rxMsg[15:8]), .rxData3(rxMsg[7:0]), .txValid(txValid),
        .txOpcode(txMsg[39:32]), .txAddr(txMsg[31:24]),
        .txData1(txMsg[23:16]), .txData2(txMsg[15:8]),
        .txData3(txMsg[7:0]), .txReady(txReady),
        .busyRelease(busyRelease), .onPriorityChan(onPriorityChan),
        .modeChange(modeChange), .opVolWrite(opVolWrite),
        .opVolume(opVolume), .scanResume(scanResume),
        .activeVol(activeVol), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata));
    boh_option_model boh_option_model_i (.mclk(mclk), .slow(slow),
        .rxValid(rxValid), .rxRequest(rxRequest), .rxMsg(rxMsg),
        .txValid(txValid), .txMsg(txMsg), .txReady(txReady));
    // Head of the last message the option took
    wire logic [31:0] gotHead = boh_option_model_i.gotMsg[39:8];
    // Clock and a hang guard well above the whole run
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            n_errors++;
            $display("[FAIL] %0t run did not finish", $time);
            tally_and_finish();
        end
    end
    task automatic check(input logic [39:0] got, exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Register port: one-cycle strobes, read data in the following cycle
    task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge mclk);
        regRead <= 1'b0;
        #1 rd = regRdata;
        @(posedge mclk);
    endtask
    // Send, then give the level time to settle
    task automatic msg(input logic req, input logic [39:0] m);
        boh_option_model_i.send(req, m);
        repeat (4) @(posedge mclk);
    endtask
    task automatic wait_tx(input int n0);
        for (int k = 0; k < 200 && boh_option_model_i.nTx == n0; k++)
            @(posedge mclk);
        @(posedge mclk);
    endtask
    task automatic t_scan;
        boh_option_model_i.send(1'b0, {boh_pkg::OP_SCAN_UNQ, 32'h0});
        #1 check(40'(scanResume), 40'h1, "scan resume");
        @(posedge mclk);
        #1 check(40'(scanResume), 40'h0, "scan pulse");
        @(posedge mclk);
        onPriorityChan <= 1'b1;
        boh_option_model_i.send(1'b0, {boh_pkg::OP_SCAN_UNQ, 32'h0});
        #1 check(40'(scanResume), 40'h0, "priority");
        @(posedge mclk);
        onPriorityChan <= 1'b0;
        $display("scan test done");
    endtask
    task automatic t_repeater;
        msg(1'b0, {boh_pkg::OP_REP_STAT, 32'h00030000});
        reg_rd(boh_pkg::REG_STATUS);
        check(40'(rd), 40'h000c, "repeater on, sending");
        msg(1'b0, {boh_pkg::OP_REP_STAT, 32'h00010000});
        reg_rd(boh_pkg::REG_STATUS);
        check(40'(rd), 40'h0004, "repeater on, receiving");
        $display("repeater test done");
    endtask
    task automatic t_volume;
        int n0;
        reg_rd(4'hf);
        check(40'(rd), 40'h0, "unmapped");
        check(40'(activeVol), 40'h80, "reset volume");
        reg_wr(boh_pkg::REG_CTRL, 16'h0090);
        msg(1'b0, {boh_pkg::OP_VOL_FLOOR, 32'h00010000});
        check(40'(activeVol), 40'h90, "floor raise");
        n0 = boh_option_model_i.nTx;
        msg(1'b1, {boh_pkg::OP_VOL_LEVEL, 32'h02000000});
        wait_tx(n0);
        check(boh_option_model_i.gotMsg, 40'h2702000080, "read");
        reg_wr(boh_pkg::REG_CTRL, 16'h0040);
        msg(1'b0, {boh_pkg::OP_VOL_FLOOR, 32'h00010000});
        check(40'(activeVol), 40'h80, "floor keeps");
        msg(1'b0, {boh_pkg::OP_VOL_FLOOR, 32'h00000000});
        check(40'(activeVol), 40'h80, "floor off");
        msg(1'b0, {boh_pkg::OP_VOL_LEVEL, 32'h020100ff});
        check(40'(activeVol), 40'hff, "level write");
        msg(1'b0, {boh_pkg::OP_VOL_LEVEL, 32'h02020033});
        check(40'(activeVol), 40'h33, "level write 2");
        modeChange <= 1'b1;
        @(posedge mclk);
        modeChange <= 1'b0;
        repeat (3) @(posedge mclk);
        check(40'(activeVol), 40'h80, "mode revert");
        $display("volume test done");
    endtask
    task automatic t_xfer;
        int n0 = boh_option_model_i.nTx;
        msg(1'b0, {boh_pkg::OP_XSTART, 32'h01020300});
        msg(1'b0, {boh_pkg::OP_XBODY, 32'h01aabb00});
        msg(1'b0, {boh_pkg::OP_XSTART, 32'h02000000});
        msg(1'b0, {boh_pkg::OP_XBODY, 32'h01ccdd00});
        msg(1'b0, {boh_pkg::OP_XEND, 32'h01020300});
        wait_tx(n0);
        check(40'(gotHead), 40'h53010600, "ack");
        reg_wr(boh_pkg::REG_XSEL, 16'h0012);
        reg_rd(boh_pkg::REG_XDATA);
        check(40'(rd), 40'h06aa, "buffer");
        n0 = boh_option_model_i.nTx;
        msg(1'b0, {boh_pkg::OP_XSTART, 32'h03001000});
        wait_tx(n0);
        check(40'(gotHead), 40'h53030005, "size");
        // Option 0 runs past the end of its buffer on the second body
        msg(1'b0, {boh_pkg::OP_XSTART, 32'h000e0300});
        msg(1'b0, {boh_pkg::OP_XBODY, 32'h00112200});
        n0 = boh_option_model_i.nTx;
        msg(1'b0, {boh_pkg::OP_XBODY, 32'h00334400});
        wait_tx(n0);
        check(40'(gotHead), 40'h53001005, "overflow");
        reg_wr(boh_pkg::REG_XSEL, 16'h0000);
        reg_rd(boh_pkg::REG_XDATA);
        check(40'(rd), 40'h1200, "discard");
        $display("transfer test done");
    endtask
    task automatic t_xtal;
        int n0 = boh_option_model_i.nTx;
        slow <= 1'b1;
        busyRelease <= 1'b1;
        @(posedge mclk);
        busyRelease <= 1'b0;
        reg_wr(boh_pkg::REG_XTAL, 16'h0120);
        repeat (15) begin
            @(posedge mclk);
            check(40'(txValid), 40'h0, "gap");
        end
        wait_tx(n0);
        check(40'(gotHead), 40'h54010120, "xtal");
        check(40'(boh_option_model_i.xtalShift), 40'h1, "group");
        $display("crystal test done");
    endtask
    // Reset for three cycles, then the scenarios in turn
    initial begin
        reset_n = 1'b0;
        {busyRelease, onPriorityChan, modeChange, opVolWrite} = '0;
        {regWrite, regRead, slow} = '0;
        opVolume = 8'h80;
        regAddr = '0;
        regWdata = '0;
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        @(posedge mclk);
        t_scan();
        t_repeater();
        t_volume();
        t_xfer();
        t_xtal();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
